// [dv/pcw_assertions.sv]
`timescale 1ns/1ps
module pcw_assertions
  import pcw_pkg::*;
(
  // Clock and reset
  input logic sys_clk,
  input logic rst_n,
  // Watched
  input logic shared_pin,
  input logic [31:0] pll_config_word_two,
  input logic pump_negative,
  input logic pump_preset_midrail,
  input logic shared_pin_function_select,
  input logic [3:0] pump_current,
  input logic [1:0] phase_detector_width,
  input logic [2:0] feedback_selector,
  input logic [14:0] out_selects,
  input logic power_down_n,
  input logic divider_reset,
  input logic pump_tristate
);
  logic [31:0] w_d;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) w_d <= 32'hdb6db4a2;
    else w_d <= pll_config_word_two;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_pump_dir: assert property (pump_negative == w_d[2])
    else $error("direction");
  a_pump_preset: assert property (pump_preset_midrail == w_d[3])
    else $error("preset");
  a_pin_func: assert property (shared_pin_function_select == w_d[29])
    else $error("pin function");
  a_pump_cur: assert property (pump_current == w_d[7:4])
    else $error("current");
  a_pfd_width: assert property (phase_detector_width == w_d[9:8])
    else $error("pfd");
  a_fb_sel: assert property (feedback_selector == w_d[12:10])
    else $error("feedback");
  a_out_sel: assert property (out_selects == w_d[27:13])
    else $error("outputs");
  a_power_down: assert property (power_down_n == w_d[28])
    else $error("power down");
  a_div_reset: assert property ($stable(shared_pin) |->
    divider_reset == (!w_d[30] || (shared_pin && !w_d[29]))) else $error("divider");
  a_pump_tri: assert property ($stable(shared_pin) |->
    pump_tristate == (!w_d[31] || (shared_pin && w_d[29]))) else $error("tristate");
  a_word_addr: assert property ($changed(pll_config_word_two) |->
    pll_config_word_two[1:0] == 2'h2) else $error("address");
endmodule
bind pcw_top pcw_assertions chk (.*);

// [dv/pcw_host.sv]
`timescale 1ns/1ps
module pcw_host (
  // Clock
  input logic sys_clk,
  // Serial port
  output logic ser_clk,
  output logic ser_data,
  output logic ser_le
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_le = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic send(input logic [31:0] w);
    ser_le = 1'b0;
    tick(2);
    for (int i = 31; i >= 0; i--) begin
      ser_data = w[i];
      tick(2);
      ser_clk = 1'b1;
      tick(2);
      ser_clk = 1'b0;
    end
    ser_le = 1'b1;
    ser_data = ~ser_data; // Released line must not look held
    tick(6);
  endtask
endmodule

// [dv/pcw_top_tb.sv]
`timescale 1ns/1ps
module pcw_top_tb;
  import pcw_pkg::*;
  logic sys_clk, rst_n, ser_clk, ser_data, ser_le, shared_pin;
  logic [31:0] pll_config_word_two;
  logic pump_negative, pump_preset_midrail, pump_tristate, power_down_n;
  logic shared_pin_function_select, divider_reset;
  logic [3:0] pump_current;
  logic [1:0] phase_detector_width;
  logic [2:0] feedback_selector;
  logic [14:0] out_selects;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  pcw_top dut (.*);
  pcw_host host (.*);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_all(input logic [31:0] w, input logic pin);
    chk("word", w, pll_config_word_two);
    chk("dir", w[2], pump_negative);
    chk("preset", w[3], pump_preset_midrail);
    chk("current", w[7:4], pump_current);
    chk("pfd", w[9:8], phase_detector_width);
    chk("fb", w[12:10], feedback_selector);
    chk("outs", w[27:13], out_selects);
    chk("pd_n", w[28], power_down_n);
    chk("pinfn", w[29], shared_pin_function_select);
    chk("divrst", !w[30] || (pin && !w[29]), divider_reset);
    chk("tri", !w[31] || (pin && w[29]), pump_tristate);
  endtask
  task automatic t_reset();
    chk_all(32'hdb6db4a2, 1'b0);
  endtask
  task automatic t_load();
    host.send(32'h5a5a5a5a);
    chk_all(32'h5a5a5a5a, 1'b0);
    host.send(32'ha5a5a5a6);
    chk_all(32'ha5a5a5a6, 1'b0);
  endtask
  task automatic t_refuse();
    for (int c = 0; c < 4; c++) begin
      if (c != 2) begin
        host.send({30'h3fffffff, c[1:0]});
        chk_all(32'ha5a5a5a6, 1'b0);
      end
    end
  endtask
  task automatic t_pin();
    shared_pin = 1'b1;
    host.send(32'hffffffe2);
    chk_all(32'hffffffe2, 1'b1);
    host.send(32'hdb6db4a2);
    chk_all(32'hdb6db4a2, 1'b1);
    shared_pin = 1'b0;
  endtask
  task automatic t_rerun();
    rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    chk_all(32'hdb6db4a2, 1'b0);
  endtask
  task automatic give_verdict();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    shared_pin = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_load();
    t_refuse();
    t_pin();
    t_rerun();
    give_verdict();
  end
endmodule

// [logic/pcw_decode.sv]
`timescale 1ns/1ps
module pcw_decode
  import pcw_pkg::*;
(
  // Stored word
  input wire logic [31:0] cfg,
  // Decoded controls
  output logic pump_negative,
  output logic pump_preset_midrail,
  output logic [3:0] pump_current,
  output logic [1:0] phase_detector_width,
  output logic [2:0] feedback_selector,
  output logic [14:0] out_selects,
  output logic power_down_n,
  output logic shared_pin_function_select,
  output logic divider_reset,
  output logic pump_tristate
);
  always_comb begin
    pump_negative = cfg[PCW_POS_DIR];
    pump_preset_midrail = cfg[PCW_POS_PRESET];
    pump_current = cfg[PCW_POS_CUR +: 4];
    phase_detector_width = cfg[PCW_POS_PFD +: 2];
    feedback_selector = cfg[PCW_POS_FB +: 3];
    out_selects = cfg[PCW_POS_OUT +: 15];
    power_down_n = cfg[PCW_POS_PD];
    shared_pin_function_select = cfg[PCW_POS_PINFN];
    divider_reset = 1'b0;
    pump_tristate = 1'b0;
    if (!cfg[PCW_POS_DIVRST]) begin
      divider_reset = 1'b1;
    end
    if (!cfg[PCW_POS_TRI]) begin
      pump_tristate = 1'b1;
    end
  end
endmodule

// [logic/pcw_pkg.sv]
package pcw_pkg;
  localparam int unsigned PCW_WORD_W = 32;
  localparam int unsigned PCW_SEL_W = 3;
  localparam int unsigned PCW_NUM_OUT = 5;
  localparam logic [1:0] PCW_ADDR_CODE = 2'h2;
  localparam int unsigned PCW_POS_ADDR = 0;
  localparam int unsigned PCW_POS_DIR = 2;
  localparam int unsigned PCW_POS_PRESET = 3;
  localparam int unsigned PCW_POS_CUR = 4;
  localparam int unsigned PCW_POS_PFD = 8;
  localparam int unsigned PCW_POS_FB = 10;
  localparam int unsigned PCW_POS_OUT = 13;
  localparam int unsigned PCW_POS_PD = 28;
  localparam int unsigned PCW_POS_PINFN = 29;
  localparam int unsigned PCW_POS_DIVRST = 30;
  localparam int unsigned PCW_POS_TRI = 31;
  localparam logic [31:0] PCW_RESET_VALUE = 32'hdb6db4a2;
  localparam logic [3:0] PCW_CUR_RESET = 4'ha;
  localparam logic [1:0] PCW_PFD_RESET = 2'h0;
  localparam logic [2:0] PCW_SEL_RESET = 3'h5;
  typedef enum logic [1:0] {PCW_IDLE, PCW_SHIFT, PCW_LATCH} pcw_state_t;
endpackage

// [logic/pcw_shifter.sv]
`timescale 1ns/1ps
module pcw_shifter
  import pcw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial port
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  // Assembled word
  pcw_word_if.src wo
);
  pcw_state_t state_reg, state_next;
  logic [31:0] sh_reg, sh_next;
  logic clk_d_reg;
  logic word_valid_reg, word_valid_next;

  // Data sampled on serial clock rise, MSB first
  always_comb begin
    state_next = state_reg;
    sh_next = sh_reg;
    word_valid_next = 1'b0;
    case (state_reg)
      PCW_IDLE: begin
        if (!ser_le) begin
          state_next = PCW_SHIFT;
        end
      end
      PCW_SHIFT: begin
        if (ser_clk && !clk_d_reg) begin
          sh_next = {sh_reg[30:0], ser_data};
        end
        if (ser_le) begin
          state_next = PCW_LATCH;
        end
      end
      PCW_LATCH: begin
        word_valid_next = 1'b1;
        state_next = PCW_IDLE;
      end
      default: state_next = PCW_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PCW_IDLE;
      sh_reg <= 32'h0;
      clk_d_reg <= 1'b0;
      word_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sh_reg <= sh_next;
      clk_d_reg <= ser_clk;
      word_valid_reg <= word_valid_next;
    end
  end

  assign wo.word_valid = word_valid_reg;
  assign wo.word = sh_reg;
endmodule

// [logic/pcw_top.sv]
// Operation
// - Direction bit clear gives positive pump current, set gives negative, reference leading.
// - Preset bit set forces the pump output to half the pump supply.
// - Bits 4 to 7 are the pump current code, LSB at bit 4, reset 1010.
// - Bits 8 and 9 are the phase detector width code, reset zero.
// - Bits 10 to 12 are the feedback select code, reset 101.
// - Five 3-bit output select codes fill bits 13 to 27, each reset 101.
// - Bit 28 is active-low power down, reset set.
// - Bit 29 makes the shared pin a divider reset when clear, a hold input when set.
// - Clearing bit 30 resets all dividers like the reset pin; reset set.
// - Clearing bit 31 tri-states the pump like the hold pin; reset set.
`timescale 1ns/1ps
module pcw_top
  import pcw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial programming port
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_le,
  // Shared control pin level
  input wire logic shared_pin,
  // Stored word
  output logic [31:0] pll_config_word_two,
  // Pump controls
  output logic pump_negative,
  output logic pump_preset_midrail,
  output logic [3:0] pump_current,
  output logic [1:0] phase_detector_width,
  output logic pump_tristate,
  // Selects
  output logic [2:0] feedback_selector,
  output logic [14:0] out_selects,
  // Device controls
  output logic power_down_n,
  output logic shared_pin_function_select,
  output logic divider_reset
);
  pcw_word_if wbus ();
  logic [31:0] cfg_reg, cfg_next;
  logic d_neg, d_pre, d_pd, d_fn, d_drst, d_tri;
  logic [3:0] d_cur;
  logic [1:0] d_pfd;
  logic [2:0] d_fb;
  logic [14:0] d_out;
  logic drst_reg, drst_next, tri_reg, tri_next;
  logic [27:0] ctl_reg, ctl_next;

  pcw_shifter u_shift (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .ser_le(ser_le),
    .wo(wbus.src)
  );

  // Other word codes go to other registers
  always_comb begin
    cfg_next = cfg_reg;
    if (wbus.word_valid && wbus.word[PCW_POS_ADDR +: 2] == PCW_ADDR_CODE) begin
      cfg_next = wbus.word;
    end
  end

  pcw_decode u_dec (
    .cfg(cfg_reg),
    .pump_negative(d_neg),
    .pump_preset_midrail(d_pre),
    .pump_current(d_cur),
    .phase_detector_width(d_pfd),
    .feedback_selector(d_fb),
    .out_selects(d_out),
    .power_down_n(d_pd),
    .shared_pin_function_select(d_fn),
    .divider_reset(d_drst),
    .pump_tristate(d_tri)
  );

  // Pin acts in the role chosen by bit 29, ORed with the soft bits
  always_comb begin
    ctl_next = {d_neg, d_pre, d_cur, d_pfd, d_fb, d_out, d_pd, d_fn};
    drst_next = d_drst || (!d_fn && shared_pin);
    tri_next = d_tri || (d_fn && shared_pin);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= PCW_RESET_VALUE;
      ctl_reg <= {1'b0, 1'b0, PCW_CUR_RESET, PCW_PFD_RESET, PCW_SEL_RESET,
                  {PCW_SEL_RESET, PCW_SEL_RESET, PCW_SEL_RESET, PCW_SEL_RESET,
                   PCW_SEL_RESET}, 1'b1, 1'b0};
      drst_reg <= 1'b0;
      tri_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      ctl_reg <= ctl_next;
      drst_reg <= drst_next;
      tri_reg <= tri_next;
    end
  end

  always_comb begin
    pll_config_word_two = cfg_reg;
    {pump_negative, pump_preset_midrail, pump_current, phase_detector_width,
     feedback_selector, out_selects, power_down_n, shared_pin_function_select} = ctl_reg;
    divider_reset = drst_reg;
    pump_tristate = tri_reg;
  end
endmodule

// [logic/pcw_word_if.sv]
`timescale 1ns/1ps
interface pcw_word_if;
  logic word_valid;
  logic [31:0] word;
  modport src (output word_valid, output word);
  modport dst (input word_valid, input word);
endinterface
